/* File: pmm_assertions.sv */
// concurrent checks on the power mode manager ports
`timescale 1ns/1ps
module pmm_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rfFieldPresent,
  input wire logic waitInterruptInstruction,
  input wire logic cpuIrq,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic coreOn,
  input wire logic ioOn,
  input wire logic mainOscOn,
  input wire logic nfcOn,
  input wire logic regulatorOn,
  input wire logic regFromRf,
  input wire logic bridgeChargeEn,
  input wire logic coreRst_n,
  input wire logic cpuClkEn,
  input wire logic fastClkTick,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  release_order_a:
  assert property (coreRst_n |-> coreOn && ioOn && mainOscOn)
    else $error("core released before power and oscillator");
  regulator_on_a:
  assert property (coreOn |-> regulatorOn)
    else $error("core without regulator");
  charge_source_a:
  assert property (bridgeChargeEn |-> regFromRf)
    else $error("charge not from rf");
  nfc_on_a:
  assert property (rfFieldPresent [*5] |-> nfcOn)
    else $error("nfc off with field");
  nfc_off_a:
  assert property (!rfFieldPresent [*5] |-> !nfcOn)
    else $error("nfc on, no field");
  tick_needs_osc_a:
  assert property (fastClkTick |-> mainOscOn)
    else $error("tick without osc");
  sleep_entry_a:
  assert property (coreRst_n && cpuClkEn && waitInterruptInstruction
    && !cpuIrq |-> ##[1:3] !cpuClkEn) else $error("no sleep on wait");
  irq_wake_a:
  assert property (coreRst_n && !cpuClkEn && cpuIrq |-> ##[1:3] cpuClkEn)
    else $error("sleep not left on interrupt");
  bresp_hold_a:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  read_answer_a:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hold_a:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer unstable");
  cover property ($rose(bridgeChargeEn));
  cover property ($rose(coreRst_n));
  cover property ($fell(coreRst_n));
  cover property (coreRst_n && $fell(cpuClkEn));
  cover property ($rose(irq));
endmodule // pmm_assertions

bind power_mode_manager pmm_assertions i_chk (
  .clock(clock), .rst_n(rst_n), .rfFieldPresent(rfFieldPresent),
  .waitInterruptInstruction(waitInterruptInstruction), .cpuIrq(cpuIrq),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .coreOn(coreOn), .ioOn(ioOn), .mainOscOn(mainOscOn), .nfcOn(nfcOn),
  .regulatorOn(regulatorOn), .regFromRf(regFromRf),
  .bridgeChargeEn(bridgeChargeEn), .coreRst_n(coreRst_n),
  .cpuClkEn(cpuClkEn), .fastClkTick(fastClkTick), .irq(irq)
);

/* File: pmm_clk_div.sv */
// fast clock enable divider: pulse every (div+1) slow clock cycles
`timescale 1ns/1ps
module pmm_clk_div #(
  parameter int DW = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [DW-1:0] div,
  output logic tick
);
  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q >= div) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end else begin
      cnt_d = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule // pmm_clk_div

/* File: pmm_pkg.sv */
// constants and types of the power mode manager
package pmm_pkg;
  localparam int SLOW_CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WAKE = 8'h04;
  localparam logic [7:0] REG_TMR = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_RTC = 8'h18;
  // control register fields
  localparam int CTRL_SAVE_REQ = 0;
  localparam int CTRL_NVM_ON = 1;
  localparam int CTRL_DIV_LSB = 4;
  localparam int DIV_W = 4;
  // wake register fields
  localparam int WAKE_RF_EN = 0;
  localparam int WAKE_PIN_EN = 1;
  localparam int WAKE_PIN_POL = 2;
  localparam int WAKE_TMR_EN = 3;
  // reset values
  localparam logic CTRL_NVM_RST = 1'b1;
  localparam logic [3:0] WAKE_RST = 4'h0;
  localparam logic [3:0] DIV_RST = 4'h0;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int EV_STARTUP = 0;
  localparam int EV_SAVE = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_TMR = 3;
  // oscillator settle time in cycles
  localparam int OSC_SETTLE_CYC = 16;
  localparam int CAP_CHARGE_CYC = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PM_OFF = 3'b000,
    PM_CHARGE = 3'b001,
    PM_OSC = 3'b010,
    PM_RUN = 3'b011,
    PM_SLEEP = 3'b100,
    PM_SAVE = 3'b101
  } pmm_state_t;
endpackage

/* File: pmm_sync.sv */
// two flip-flop synchroniser for a level
`timescale 1ns/1ps
module pmm_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign dout = sync_q;
endmodule // pmm_sync

/* File: power_mode_manager.sv */
// power mode manager of the always-on standby domain
`timescale 1ns/1ps
// What this block does
// - start up into operation mode when supplied
// - detect main supply, then sequence start-up
// - software request moves chip to power save
// - power save: core, io, nvm, bridge, osc off
// - nvm power follows software bit, default on
// - nfc domain on only with rf field
// - enabled wake conditions return to operation
// - rf field detection wakes when enabled
// - wake pin level wakes, polarity selectable
// - standby timer counts ticks, wakes at count
// - standby domain holds wake timer and rtc
// - regulators enabled from supply or rf
// - bridge capacitor charged from rf, controlled
// - wait instructions put cpu to sleep
// - interrupt ends sleep, restores cpu clock
// - sleep gates the cpu clock only
// - fast clock divided by software setting
// - runs from the always-on slow clock
module power_mode_manager
  import pmm_pkg::*;
#(
  parameter int TMR_W = 32,
  parameter int SETTLE = OSC_SETTLE_CYC,
  parameter int CHARGE = CAP_CHARGE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic supplyPresent,
  input wire logic rfFieldPresent,
  input wire logic wakePin,
  input wire logic waitInterruptInstruction,
  input wire logic waitEventInstruction,
  input wire logic cpuIrq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic coreOn,
  output logic ioOn,
  output logic nvmOn,
  output logic bridgeOn,
  output logic nfcOn,
  output logic mainOscOn,
  output logic regulatorOn,
  output logic regFromRf,
  output logic bridgeChargeEn,
  output logic coreRst_n,
  output logic cpuClkEn,
  output logic fastClkTick,
  output logic irq
);
  // synchronised pins
  logic supSync;
  logic rfSync;
  logic pinSync;
  pmm_sync uSyncSup (.clock(clock), .rst_n(rst_n), .din(supplyPresent),
    .dout(supSync));
  pmm_sync uSyncRf (.clock(clock), .rst_n(rst_n), .din(rfFieldPresent),
    .dout(rfSync));
  pmm_sync uSyncPin (.clock(clock), .rst_n(rst_n), .din(wakePin),
    .dout(pinSync));

  pmm_state_t st_q, st_d;
  logic [15:0] seq_q, seq_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] tmrLim_q, tmrLim_d;
  logic [31:0] rtc_q, rtc_d;
  logic nvmCtl_q, nvmCtl_d;
  logic saveReq_q, saveReq_d;
  logic [3:0] wake_q, wake_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] mask_q, mask_d;
  logic [IRQ_W-1:0] ev;
  logic irq_q, irq_d;
  logic fromRf_q, fromRf_d;
  // bus state
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic doWrite, wakeHit, tmrHit, powered;
  logic [31:0] wrMasked;
  logic [2:0] rdy_q, rdy_d;

  function automatic logic isMapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_WAKE || a == REG_TMR ||
      a == REG_STAT || a == REG_IRQ || a == REG_MASK || a == REG_RTC;
  endfunction

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign powered = supSync || rfSync;
  assign doWrite = awHave_q && wHave_q && !bValid_q;
  assign wrMasked = strbMerge(32'h0, wData_q, wStrb_q);
  assign tmrHit = wake_q[WAKE_TMR_EN] && (tmr_q >= tmrLim_q);
  // any enabled source wakes
  assign wakeHit = (wake_q[WAKE_RF_EN] && rfSync) ||
    (wake_q[WAKE_PIN_EN] && (pinSync == wake_q[WAKE_PIN_POL])) ||
    tmrHit;

  // power state sequence
  always_comb begin
    st_d = st_q;
    seq_d = seq_q;
    tmr_d = tmr_q;
    fromRf_d = fromRf_q;
    ev = '0;
    case (st_q)
      PM_OFF: begin
        seq_d = '0;
        if (powered) begin
          fromRf_d = !supSync;
          st_d = supSync ? PM_OSC : PM_CHARGE;
        end
      end
      PM_CHARGE: begin
        seq_d = seq_q + 16'h0001;
        if (!powered) begin
          st_d = PM_OFF;
        end else if (seq_q >= 16'(CHARGE - 1)) begin
          seq_d = '0;
          st_d = PM_OSC;
        end
      end
      PM_OSC: begin
        seq_d = seq_q + 16'h0001;
        if (seq_q >= 16'(SETTLE - 1)) begin
          seq_d = '0;
          st_d = PM_RUN;
          ev[EV_STARTUP] = 1'b1;
        end
      end
      PM_RUN: begin
        if (saveReq_q) begin
          st_d = PM_SAVE;
          tmr_d = '0;
          ev[EV_SAVE] = 1'b1;
        end else if (waitInterruptInstruction || waitEventInstruction) begin
          st_d = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (cpuIrq) begin
          st_d = PM_RUN;
        end
      end
      PM_SAVE: begin
        tmr_d = tmr_q + 1'b1;
        if (wakeHit) begin
          st_d = PM_OSC;
          seq_d = '0;
          ev[EV_WAKE] = 1'b1;
          ev[EV_TMR] = tmrHit;
        end
      end
      default: st_d = PM_OFF;
    endcase
  end

  // register file and bus slave
  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    nvmCtl_d = nvmCtl_q;
    saveReq_d = saveReq_q && st_q != PM_SAVE;
    wake_d = wake_q;
    div_d = div_q;
    tmrLim_d = tmrLim_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rtc_d = rtc_q + 32'h1;
    if (s_axi_awvalid && !awHave_q) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_q) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      case (awAddr_q)
        REG_CTRL: begin
          if (wStrb_q[0]) begin
            saveReq_d = wData_q[CTRL_SAVE_REQ] && st_q == PM_RUN;
            nvmCtl_d = wData_q[CTRL_NVM_ON];
            div_d = wData_q[CTRL_DIV_LSB +: DIV_W];
          end
        end
        REG_WAKE: if (wStrb_q[0]) wake_d = wData_q[3:0];
        REG_TMR: tmrLim_d = TMR_W'(strbMerge(32'(tmrLim_q), wData_q,
          wStrb_q));
        REG_IRQ: stat_d = stat_q & ~wrMasked[IRQ_W-1:0];
        REG_MASK: if (wStrb_q[0]) mask_d = wData_q[IRQ_W-1:0];
        REG_RTC: rtc_d = strbMerge(rtc_q, wData_q, wStrb_q);
        default: ;
      endcase
    end
    stat_d = stat_d | ev; // set beats clear
    irq_d = |(stat_d & mask_d);
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL: rData_d = {24'h0, div_q, 2'b00, nvmCtl_q, saveReq_q};
        REG_WAKE: rData_d = {28'h0, wake_q};
        REG_TMR: rData_d = 32'(tmrLim_q);
        REG_STAT: rData_d = {24'h0, fromRf_q, rfSync, pinSync, supSync,
          1'b0, st_q};
        REG_IRQ: rData_d = {28'h0, stat_q};
        REG_MASK: rData_d = {28'h0, mask_q};
        REG_RTC: rData_d = rtc_q;
        default: rData_d = 32'h0;
      endcase
    end
    rdy_d = {!awHave_d, !wHave_d, !rValid_d};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= PM_OFF;
      rdy_q <= 3'b111;
      seq_q <= '0;
      tmr_q <= '0;
      tmrLim_q <= '0;
      rtc_q <= '0;
      nvmCtl_q <= CTRL_NVM_RST;
      saveReq_q <= 1'b0;
      wake_q <= WAKE_RST;
      div_q <= DIV_RST;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      fromRf_q <= 1'b0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q <= RESP_OKAY;
      rData_q <= '0;
    end else begin
      st_q <= st_d;
      seq_q <= seq_d;
      tmr_q <= tmr_d;
      tmrLim_q <= tmrLim_d;
      rtc_q <= rtc_d;
      nvmCtl_q <= nvmCtl_d;
      saveReq_q <= saveReq_d;
      wake_q <= wake_d;
      div_q <= div_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      fromRf_q <= fromRf_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      rdy_q <= rdy_d;
    end
  end

  // domain outputs, registered
  logic [10:0] pwr_q, pwr_d;
  logic running, tick;
  assign running = st_d == PM_RUN || st_d == PM_SLEEP;
  always_comb begin
    pwr_d[0] = running || st_d == PM_OSC;
    pwr_d[1] = running || st_d == PM_OSC;
    pwr_d[2] = running && nvmCtl_d;
    pwr_d[3] = running;
    pwr_d[4] = rfSync;
    pwr_d[5] = st_d == PM_OSC || running;
    pwr_d[6] = st_d != PM_OFF;
    pwr_d[7] = fromRf_d;
    pwr_d[8] = st_d == PM_CHARGE || (fromRf_d && running);
    pwr_d[9] = running;
    pwr_d[10] = st_d == PM_RUN;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwr_q <= '0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  pmm_clk_div #(.DW(DIV_W)) uDiv (.clock(clock), .rst_n(rst_n),
    .run(pwr_d[5]), .div(div_q), .tick(tick));

  assign coreOn = pwr_q[0];
  assign ioOn = pwr_q[1];
  assign nvmOn = pwr_q[2];
  assign bridgeOn = pwr_q[3];
  assign nfcOn = pwr_q[4];
  assign mainOscOn = pwr_q[5];
  assign regulatorOn = pwr_q[6];
  assign regFromRf = pwr_q[7];
  assign bridgeChargeEn = pwr_q[8];
  assign coreRst_n = pwr_q[9];
  assign cpuClkEn = pwr_q[10];
  assign fastClkTick = tick;
  assign irq = irq_q;
  assign s_axi_awready = rdy_q[2];
  assign s_axi_wready = rdy_q[1];
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = rdy_q[0];
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;
endmodule // power_mode_manager

/* File: power_mode_manager_tb_top.sv */
// self-checking bench of the power mode manager
`timescale 1ns/1ps
module power_mode_manager_tb_top;
  import pmm_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, supplyPresent = 1'b1, wakePin = 1'b1;
  logic rfFieldPresent = 1'b0, cpuIrq = 1'b0;
  logic waitInterruptInstruction = 1'b0, waitEventInstruction = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] wrResp;
  logic coreOn, ioOn, nvmOn, bridgeOn, nfcOn, mainOscOn, regulatorOn;
  logic regFromRf, bridgeChargeEn, coreRst_n, cpuClkEn, fastClkTick, irq;
  int fail_count = 0;
  int checks_done = 0;

  power_mode_manager #(.SETTLE(2), .CHARGE(2)) i_dut (
    .clock(clock), .rst_n(rst_n), .supplyPresent(supplyPresent),
    .rfFieldPresent(rfFieldPresent), .wakePin(wakePin),
    .waitInterruptInstruction(waitInterruptInstruction),
    .waitEventInstruction(waitEventInstruction), .cpuIrq(cpuIrq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .coreOn(coreOn), .ioOn(ioOn),
    .nvmOn(nvmOn), .bridgeOn(bridgeOn), .nfcOn(nfcOn),
    .mainOscOn(mainOscOn), .regulatorOn(regulatorOn),
    .regFromRf(regFromRf), .bridgeChargeEn(bridgeChargeEn),
    .coreRst_n(coreRst_n), .cpuClkEn(cpuClkEn),
    .fastClkTick(fastClkTick), .irq(irq)
  );

  always #25 clock = ~clock;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // handshakes are seen at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      wrResp = s_axi_bresp;
      @(posedge clock);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, h;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ah = s_axi_arvalid && s_axi_arready;
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (!h);
    s_axi_rready <= 1'b0;
  endtask

  // bounded wait for 0 reset release, 1 cpu clock, 2 nfc power
  task automatic wt(input int s, input logic v, output int n);
    logic x;
    n = 0;
    do begin
      @(negedge clock);
      case (s)
        0: x = coreRst_n;
        1: x = cpuClkEn;
        default: x = nfcOn;
      endcase
      n++;
    end while (x !== v && n < 200);
    chk(x, v);
  endtask

  task automatic save(input logic [31:0] wk);
    wr(REG_WAKE, wk);
    wr(REG_CTRL, 32'h3);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wt(0, 1'b1, n);
    chk({coreOn, ioOn, nvmOn, bridgeOn, mainOscOn}, 5'h1F);
    chk({regulatorOn, regFromRf}, 2'b10);
    rd(REG_STAT, d, r);
    chk(d[4:0], 5'h13);
    rd(8'h1C, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h1C, 32'h0);
    chk(wrResp, RESP_SLVERR);
    wr(REG_RTC, 32'h100);
    rd(REG_RTC, d, r);
    chk(d[31:4], 28'h010);
    wr(REG_MASK, 32'h0);
    rd(REG_IRQ, d, r);
    chk(d[0], 1'b1);
    chk(irq, 1'b0);
    wr(REG_MASK, 32'hF);
    repeat (2) @(negedge clock);
    chk(irq, 1'b1);
    wr(REG_IRQ, 32'hF);
    repeat (2) @(negedge clock);
    chk(irq, 1'b0);
    wr(REG_CTRL, 32'h0);
    repeat (2) @(negedge clock);
    chk(nvmOn, 1'b0);
    wr(REG_CTRL, 32'h32);
    n = 0;
    repeat (16) @(negedge clock) n += int'(fastClkTick);
    chk(n, 4);
    chk(nvmOn, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      waitInterruptInstruction <= (i == 0);
      waitEventInstruction <= (i == 1);
      @(posedge clock);
      waitInterruptInstruction <= 1'b0;
      waitEventInstruction <= 1'b0;
      wt(1, 1'b0, n);
      chk({coreOn, nvmOn, mainOscOn}, 3'h7);
      @(posedge clock);
      cpuIrq <= 1'b1;
      @(posedge clock);
      cpuIrq <= 1'b0;
      wt(1, 1'b1, n);
    end
    wr(REG_TMR, 32'h5);
    save(32'h8);
    wt(0, 1'b0, n);
    chk({coreOn, ioOn, nvmOn, bridgeOn, mainOscOn}, 5'h0);
    wt(0, 1'b1, n);
    chk(n >= 5, 1'b1);
    rd(REG_IRQ, d, r);
    chk(d[3:1], 3'h7);
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      wakePin <= (p == 0);
      save(32'h2 + 32'(p * 4));
      wt(0, 1'b0, n);
      repeat (10) @(negedge clock);
      chk(coreRst_n, 1'b0);
      @(posedge clock);
      wakePin <= (p == 1);
      wt(0, 1'b1, n);
    end
    save(32'h1);
    wt(0, 1'b0, n);
    @(posedge clock);
    rfFieldPresent <= 1'b1;
    wt(2, 1'b1, n);
    wt(0, 1'b1, n);
    @(posedge clock);
    rfFieldPresent <= 1'b0;
    wt(2, 1'b0, n);
    // passive start: reset again with only the rf field present
    @(posedge clock);
    supplyPresent <= 1'b0;
    rfFieldPresent <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wt(0, 1'b1, n);
    chk({regFromRf, bridgeChargeEn}, 2'b11);
    rd(REG_STAT, d, r);
    chk({d[7], d[4]}, 2'b10);
    tally_and_finish();
  end
endmodule // power_mode_manager_tb_top
